// ==== adc_feed.sv ====
`timescale 1ns/1ps
// Converter datapath stand-in
module adc_feed (
	// Clock
	input wire clock,
	// Result stream
	output logic result_valid = 1'b0,
	output logic [15:0] result_data = 16'h0000,
	output logic result_is_temp = 1'b0
);
	// One pulse per conversion, lines scrambled when idle
	task send(input logic [15:0] d, input logic t);
		@(posedge clock);
		result_valid <= 1'b1;
		result_data <= d;
		result_is_temp <= t;
		@(posedge clock);
		result_valid <= 1'b0;
		result_data <= ~d;
		result_is_temp <= ~t;
	endtask
endmodule // adc_feed

// ==== adc_post_asserts.sv ====
`timescale 1ns/1ps
// Port-level checks of the result post-processing block
module adc_post_asserts #(
	parameter DATA_W = 16
) (
	// Clock and reset
	input wire clock,
	input wire srst,
	// Register bus
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	// Results and interrupt
	input wire result_valid,
	input wire [DATA_W-1:0] result_data,
	input wire result_is_temp,
	input wire corrected_valid,
	input wire [DATA_W-1:0] corrected_data,
	input wire irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	// Steps of one bus access
	sequence req_first; (avs_read || avs_write) && avs_waitrequest; endsequence
	sequence req_done; !avs_waitrequest; endsequence
	// Bus, datapath and interrupt relations
	one_wait_a: assert property (req_first |=> req_done) else $error("access not answered");
	resv_zero_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
		else $error("reserved bits set");
	result_lat_a: assert property (result_valid |=> corrected_valid) else $error("sample lost");
	result_cause_a: assert property (corrected_valid |-> $past(result_valid))
		else $error("stray sample");
	plain_pass_a: assert property (result_valid && !result_is_temp |=> corrected_data == $past(result_data))
		else $error("plain sample altered");
	zero_in_a: assert property (result_valid && result_data == 16'h0000 |=> corrected_data == 16'h0000)
		else $error("zero sample altered");
	irq_rise_a: assert property ($rose(irq) |-> $past(corrected_valid) || $past(avs_write))
		else $error("irq rose without cause");
	irq_fall_a: assert property ($fell(irq) |-> $past(corrected_valid) || $past(avs_write))
		else $error("irq fell without cause");
endmodule // adc_post_asserts

bind adc_result_postprocess_limits adc_post_asserts #(.DATA_W(DATA_W)) chk (.clock(clock),
	.srst(srst), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .result_valid(result_valid), .result_data(result_data),
	.result_is_temp(result_is_temp), .corrected_valid(corrected_valid),
	.corrected_data(corrected_data), .irq(irq));

// ==== adc_post_regs.vh ====
`ifndef ADC_POST_REGS_VH
`define ADC_POST_REGS_VH

// Byte addresses of the register words
`define LOW_LIMIT_THRESHOLD_ADDR 16'h20A8
`define LOW_LIMIT_HYSTERESIS_ADDR 16'h20AC
`define HIGH_LIMIT_THRESHOLD_ADDR 16'h20B0
`define HIGH_LIMIT_HYSTERESIS_ADDR 16'h20B4
`define RESULT_DELTA_LIMIT_ADDR 16'h20B8
`define TEMP_SENSOR_GAIN_CORRECTION_ADDR 16'h2238
`define INTERRUPT_FLAGS_FIRST_ADDR 16'h2300
`define INTERRUPT_FLAGS_SECOND_ADDR 16'h2304
`define INTERRUPT_MASK_ADDR 16'h2308
`define CONVERSION_RESULT_ADDR 16'h230C

// Reset values
`define TEMP_GAIN_RESET 15'h4000
`define LIMIT_RESET 16'h0000

// Flag bit positions in the interrupt flag words
`define LOW_LIMIT_FLAG_BIT 4
`define HIGH_LIMIT_FLAG_BIT 5
`define DELTA_ERROR_FLAG_BIT 6
`define FLAG_WIDTH 3

// Gain field layout
`define TEMP_GAIN_WIDTH 15
`define TEMP_GAIN_FRAC_BITS 14

`endif

// ==== adc_result_postprocess_limits.v ====
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Gain field is 15-bit unsigned, bit 14 weighs one, bits 13:0 fraction.
// - Temperature sensor results are multiplied by the gain value.
// - A zero gain code yields a zero result.
// - Code 0x4000 is unity gain and the reset default.
// - Codes above 0x4000 scale up, 0x7FFF gives about two.
// - Codes below 0x4000 scale down, 0x2000 gives one half.
// - Gain register resets to 0x4000, bits 31:15 read zero.
// - Low threshold is 16-bit RW, upper bits zero, resets zero.
// - A result below the low threshold sets the low flag.
// - Low flag holds until a result exceeds threshold plus hysteresis.
// - Low hysteresis is 16-bit RW, resets zero, upper bits reserved.
// - A result above the high threshold sets the high flag.
// - High flag holds until a result drops below threshold minus hysteresis.
// - Limit flags appear in both interrupt flag registers.
// - High threshold and hysteresis are 16-bit RW, reset zero.
// - Consecutive results differing beyond the delta limit set the delta flag.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`include "adc_post_regs.vh"

module adc_result_postprocess_limits #(
	parameter DATA_W = 16
) (
	// Clock and reset
	input wire clock,
	input wire srst,
	// Avalon-MM slave
	input wire [15:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	output reg [1:0] avs_response,
	// Conversion results
	input wire result_valid,
	input wire [DATA_W-1:0] result_data,
	input wire result_is_temp,
	output wire corrected_valid,
	output wire [DATA_W-1:0] corrected_data,
	// Interrupt
	output wire irq
);
	// One-hot handshake states
	localparam ST_IDLE = 2'b01;
	localparam ST_DONE = 2'b10;

	// Handshake and configuration state
	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [`TEMP_GAIN_WIDTH-1:0] temp_gain_ff;
	reg [15:0] low_thr_ff;
	reg [15:0] low_hys_ff;
	reg [15:0] high_thr_ff;
	reg [15:0] high_hys_ff;
	reg [15:0] delta_lim_ff;
	// Flags and their mask
	reg [`FLAG_WIDTH-1:0] flags_ff;
	reg [`FLAG_WIDTH-1:0] mask_ff;
	wire [`FLAG_WIDTH-1:0] nxt_flags;
	reg [`FLAG_WIDTH-1:0] flag_set;
	reg [`FLAG_WIDTH-1:0] flag_clr;
	// Conversion history
	reg [DATA_W-1:0] prev_ff;
	reg have_prev_ff;
	reg [DATA_W-1:0] last_result_ff;
	reg [31:0] nxt_rdata;
	// Bus and datapath nets
	wire access;
	wire wr_go;
	wire [31:0] wmask;
	wire [31:0] wval;
	wire [DATA_W-1:0] cur;
	wire [16:0] low_release;
	wire [16:0] high_release;
	wire [DATA_W:0] diff;
	wire [DATA_W-1:0] abs_diff;
	wire [31:0] flag_word;
	// Address decode
	wire hit_gain;
	wire hit_low_thr;
	wire hit_low_hys;
	wire hit_high_thr;
	wire hit_high_hys;
	wire hit_delta;
	wire hit_flags_first;
	wire hit_flags_second;
	wire hit_mask;
	wire hit_result;
	wire hit_flags;
	wire hit_any;
	// Per-check compare results
	wire low_below;
	wire low_above;
	wire high_above;
	wire high_below;
	wire delta_over;

	//////////////////////////////////////////////////////////////////////////
	// Gain stage
	// Other channels pass through unchanged
	temp_gain_mult #(
		.DATA_W(DATA_W),
		.GAIN_W(`TEMP_GAIN_WIDTH),
		.FRAC_W(`TEMP_GAIN_FRAC_BITS)
	) u_gain (
		.clock(clock),
		.srst(srst),
		.in_valid(result_valid),
		.in_data(result_data),
		.apply_gain(result_is_temp),
		.gain(temp_gain_ff),
		.out_valid_ff(corrected_valid),
		.out_data_ff(corrected_data)
	);

	// All checks see the corrected result
	assign cur = corrected_data;

	//////////////////////////////////////////////////////////////////////////
	// Bus handshake: one wait cycle, answer in the second
	assign access = avs_read | avs_write;
	assign avs_waitrequest = access & ~state_ff[1];
	// Writes land at the edge that ends the answer cycle
	assign wr_go = avs_write & state_ff[1];

	// Handshake state
	always @* begin
		case (state_ff)
			ST_IDLE: begin
				// Any request earns exactly one wait cycle
				if (access)
					nxt_state = ST_DONE;
				else
					nxt_state = ST_IDLE;
			end
			ST_DONE: begin
				// Answer cycle, the master samples and releases
				nxt_state = ST_IDLE;
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always @(posedge clock) begin
		if (srst)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// Byte-lane merge of write data
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
			assign wmask[gi*8 +: 8] = {8{avs_byteenable[gi]}};
		end
	endgenerate
	// Lanes with a low enable contribute nothing
	assign wval = avs_writedata & wmask;

	//////////////////////////////////////////////////////////////////////////
	// Address decode, one hit line per register word
	assign hit_gain = (avs_address == `TEMP_SENSOR_GAIN_CORRECTION_ADDR);
	assign hit_low_thr = (avs_address == `LOW_LIMIT_THRESHOLD_ADDR);
	assign hit_low_hys = (avs_address == `LOW_LIMIT_HYSTERESIS_ADDR);
	assign hit_high_thr = (avs_address == `HIGH_LIMIT_THRESHOLD_ADDR);
	assign hit_high_hys = (avs_address == `HIGH_LIMIT_HYSTERESIS_ADDR);
	assign hit_delta = (avs_address == `RESULT_DELTA_LIMIT_ADDR);
	assign hit_flags_first = (avs_address == `INTERRUPT_FLAGS_FIRST_ADDR);
	assign hit_flags_second = (avs_address == `INTERRUPT_FLAGS_SECOND_ADDR);
	assign hit_mask = (avs_address == `INTERRUPT_MASK_ADDR);
	assign hit_result = (avs_address == `CONVERSION_RESULT_ADDR);

	// Both flag words show and clear the same bits
	assign hit_flags = hit_flags_first | hit_flags_second;

	// Unmapped words read zero and answer with a decode error
	assign hit_any = hit_gain | hit_low_thr | hit_low_hys | hit_high_thr | hit_high_hys |
		hit_delta | hit_flags | hit_mask | hit_result;

	//////////////////////////////////////////////////////////////////////////
	// Configuration registers, one process per word, reserved bits dropped

	// Gain correction field, unity by default
	always @(posedge clock) begin
		if (srst)
			temp_gain_ff <= `TEMP_GAIN_RESET;
		else if (wr_go && hit_gain)
			temp_gain_ff <= (temp_gain_ff & ~wmask[14:0]) | wval[14:0];
	end

	// Low limit threshold
	always @(posedge clock) begin
		if (srst)
			low_thr_ff <= `LIMIT_RESET;
		else if (wr_go && hit_low_thr)
			low_thr_ff <= (low_thr_ff & ~wmask[15:0]) | wval[15:0];
	end

	// Low limit hysteresis
	always @(posedge clock) begin
		if (srst)
			low_hys_ff <= `LIMIT_RESET;
		else if (wr_go && hit_low_hys)
			low_hys_ff <= (low_hys_ff & ~wmask[15:0]) | wval[15:0];
	end

	// High limit threshold
	always @(posedge clock) begin
		if (srst)
			high_thr_ff <= `LIMIT_RESET;
		else if (wr_go && hit_high_thr)
			high_thr_ff <= (high_thr_ff & ~wmask[15:0]) | wval[15:0];
	end

	// High limit hysteresis
	always @(posedge clock) begin
		if (srst)
			high_hys_ff <= `LIMIT_RESET;
		else if (wr_go && hit_high_hys)
			high_hys_ff <= (high_hys_ff & ~wmask[15:0]) | wval[15:0];
	end

	// Delta limit between consecutive results
	always @(posedge clock) begin
		if (srst)
			delta_lim_ff <= `LIMIT_RESET;
		else if (wr_go && hit_delta)
			delta_lim_ff <= (delta_lim_ff & ~wmask[15:0]) | wval[15:0];
	end

	// Interrupt mask, same layout as the flag words
	always @(posedge clock) begin
		if (srst)
			mask_ff <= {`FLAG_WIDTH{1'b0}};
		else if (wr_go && hit_mask)
			mask_ff <= (mask_ff & ~wmask[6:4]) | wval[6:4];
	end

	//////////////////////////////////////////////////////////////////////////
	// Limit checks on corrected result, 17-bit sums avoid wrap
	assign low_release = {1'b0, low_thr_ff} + {1'b0, low_hys_ff};
	// A borrow in bit 16 marks a release bound below zero
	assign high_release = {1'b0, high_thr_ff} - {1'b0, high_hys_ff};
	assign diff = {1'b0, cur} - {1'b0, prev_ff};
	assign abs_diff = diff[DATA_W] ? (prev_ff - cur) : diff[DATA_W-1:0];

	// Compare results of the three checks
	assign low_below = cur < low_thr_ff;
	assign low_above = {1'b0, cur} > low_release;
	assign high_above = cur > high_thr_ff;
	// A release bound below zero can never be passed
	assign high_below = ~high_release[16] && ({1'b0, cur} < high_release);
	// No delta before the first result after reset
	assign delta_over = have_prev_ff && (abs_diff > delta_lim_ff);

	// Set and release conditions, once per conversion
	always @* begin
		flag_set = {`FLAG_WIDTH{1'b0}};
		flag_clr = {`FLAG_WIDTH{1'b0}};
		if (corrected_valid) begin
			flag_set[0] = low_below;
			flag_clr[0] = low_above;
			flag_set[1] = high_above;
			flag_clr[1] = high_below;
			flag_set[2] = delta_over;
		end
		// Software writes a one to clear
		if (wr_go && hit_flags)
			flag_clr = flag_clr | wval[6:4];
	end

	// Sticky update per flag bit, hardware set wins over any clear
	generate
		for (gi = 0; gi < `FLAG_WIDTH; gi = gi + 1) begin : g_flag
			assign nxt_flags[gi] = (flags_ff[gi] & ~flag_clr[gi]) | flag_set[gi];
		end
	endgenerate

	// Flag register
	always @(posedge clock) begin
		if (srst)
			flags_ff <= {`FLAG_WIDTH{1'b0}};
		else
			flags_ff <= nxt_flags;
	end

	// History for the delta check and the result read-back
	always @(posedge clock) begin
		if (srst) begin
			prev_ff <= {DATA_W{1'b0}};
			have_prev_ff <= 1'b0;
			last_result_ff <= {DATA_W{1'b0}};
		end else if (corrected_valid) begin
			prev_ff <= cur;
			have_prev_ff <= 1'b1;
			last_result_ff <= cur;
		end
	end

	// Level interrupt while any unmasked flag is set
	assign irq = |(flags_ff & mask_ff);

	//////////////////////////////////////////////////////////////////////////
	// Read mux
	// Flag bits sit at 6:4 in both flag words
	assign flag_word = {25'h0, flags_ff, 4'h0};

	always @* begin
		nxt_rdata = 32'h00000000;
		case (avs_address)
			// Configuration words, reserved bits read zero
			`TEMP_SENSOR_GAIN_CORRECTION_ADDR: nxt_rdata = {17'h0, temp_gain_ff};
			`LOW_LIMIT_THRESHOLD_ADDR: nxt_rdata = {16'h0000, low_thr_ff};
			`LOW_LIMIT_HYSTERESIS_ADDR: nxt_rdata = {16'h0000, low_hys_ff};
			`HIGH_LIMIT_THRESHOLD_ADDR: nxt_rdata = {16'h0000, high_thr_ff};
			`HIGH_LIMIT_HYSTERESIS_ADDR: nxt_rdata = {16'h0000, high_hys_ff};
			`RESULT_DELTA_LIMIT_ADDR: nxt_rdata = {16'h0000, delta_lim_ff};
			// Status words
			`INTERRUPT_FLAGS_FIRST_ADDR: nxt_rdata = flag_word;
			`INTERRUPT_FLAGS_SECOND_ADDR: nxt_rdata = flag_word;
			`INTERRUPT_MASK_ADDR: nxt_rdata = {25'h0, mask_ff, 4'h0};
			`CONVERSION_RESULT_ADDR: nxt_rdata = {16'h0000, last_result_ff};
			default: nxt_rdata = 32'h00000000;
		endcase
	end

	// Read data, captured in the wait cycle and held for the answer
	always @(posedge clock) begin
		if (srst)
			avs_readdata <= 32'h00000000;
		else if (access & state_ff[0])
			avs_readdata <= avs_read ? nxt_rdata : 32'h00000000;
	end

	// Response code, decode error for an unmapped word
	always @(posedge clock) begin
		if (srst)
			avs_response <= 2'b00;
		else if (access & state_ff[0])
			avs_response <= hit_any ? 2'b00 : 2'b11;
	end
endmodule // adc_result_postprocess_limits

// ==== adc_result_postprocess_limits_tb.sv ====
`timescale 1ns/1ps
`include "adc_post_regs.vh"
module adc_result_postprocess_limits_tb;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [15:0] avs_address = 16'h0000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hF;
	wire [31:0] avs_readdata;
	wire avs_waitrequest;
	wire [1:0] avs_response;
	wire result_valid;
	wire [15:0] result_data;
	wire result_is_temp;
	wire corrected_valid;
	wire [15:0] corrected_data;
	wire irq;
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic [31:0] ex;
	logic [1:0] rsp;
	logic [15:0] cd;
	logic [15:0] ra [0:5] = '{`LOW_LIMIT_THRESHOLD_ADDR, `LOW_LIMIT_HYSTERESIS_ADDR,
		`HIGH_LIMIT_THRESHOLD_ADDR, `HIGH_LIMIT_HYSTERESIS_ADDR, `RESULT_DELTA_LIMIT_ADDR,
		`TEMP_SENSOR_GAIN_CORRECTION_ADDR};
	logic [14:0] gc [0:6] = '{15'h0000, 15'h4000, 15'h4001, 15'h7FFF, 15'h2000, 15'h3FFF, 15'h0001};
	// Clock
	always #5 clock = ~clock;
	adc_result_postprocess_limits dut (.clock(clock), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.avs_response(avs_response), .result_valid(result_valid), .result_data(result_data),
		.result_is_temp(result_is_temp), .corrected_valid(corrected_valid),
		.corrected_data(corrected_data), .irq(irq));
	adc_feed feed (.clock(clock), .result_valid(result_valid), .result_data(result_data),
		.result_is_temp(result_is_temp));
	task check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One bus access held until waitrequest drops
	task acc(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clock);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		@(posedge clock iff !avs_waitrequest);
		rd = avs_readdata;
		rsp = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// One conversion, corrected value captured
	task smp(input logic [15:0] d, input logic t);
		feed.send(d, t);
		@(posedge clock iff corrected_valid);
		cd = corrected_data;
		@(posedge clock);
	endtask
	task flags(input logic [31:0] e);
		acc(1'b0, `INTERRUPT_FLAGS_FIRST_ADDR, 32'h0);
		check(rd, e);
		acc(1'b0, `INTERRUPT_FLAGS_SECOND_ADDR, 32'h0);
		check(rd, e);
	endtask
	task close_out;
		if (mismatches == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			close_out;
		end
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge clock);
		srst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			acc(1'b0, ra[i], 32'h0);
			check(rd, (i == 5) ? 32'h4000 : 32'h0);
			acc(1'b1, ra[i], 32'hFFFFFFFF);
			acc(1'b0, ra[i], 32'h0);
			check(rd, (i == 5) ? 32'h7FFF : 32'hFFFF);
		end
		acc(1'b0, 16'h2000, 32'h0);
		check({rd[31:2], rsp}, 32'h3);
		avs_byteenable <= 4'h2;
		acc(1'b1, ra[0], 32'h0);
		avs_byteenable <= 4'hF;
		acc(1'b0, ra[0], 32'h0);
		check(rd, 32'h00FF);
		acc(1'b1, ra[0], 32'h0);
		for (int i = 0; i < 7; i++) begin
			acc(1'b1, ra[5], {17'h0, gc[i]});
			smp(16'hC003, 1'b1);
			ex = (32'hC003 * gc[i]) >> 14;
			check(cd, (ex > 32'hFFFF) ? 32'hFFFF : ex);
		end
		smp(16'hC003, 1'b0);
		check(cd, 32'hC003);
		acc(1'b0, `CONVERSION_RESULT_ADDR, 32'h0);
		check(rd, 32'hC003);
		smp(16'h0000, 1'b1);
		check(cd, 32'h0);
		acc(1'b1, ra[0], 32'h1000);
		acc(1'b1, ra[1], 32'h0100);
		acc(1'b1, `INTERRUPT_FLAGS_FIRST_ADDR, 32'h70);
		acc(1'b1, `INTERRUPT_MASK_ADDR, 32'h10);
		smp(16'h0FFF, 1'b0);
		flags(32'h10);
		check(irq, 32'h1);
		smp(16'h1100, 1'b0);
		flags(32'h10);
		smp(16'h1101, 1'b0);
		flags(32'h0);
		check(irq, 32'h0);
		acc(1'b1, ra[2], 32'h8000);
		acc(1'b1, ra[3], 32'h0800);
		smp(16'h8001, 1'b0);
		flags(32'h20);
		check(irq, 32'h0);
		smp(16'h7800, 1'b0);
		flags(32'h20);
		smp(16'h77FF, 1'b0);
		flags(32'h0);
		acc(1'b1, ra[4], 32'h0010);
		smp(16'h7000, 1'b0);
		acc(1'b1, `INTERRUPT_FLAGS_SECOND_ADDR, 32'h70);
		smp(16'h7010, 1'b0);
		flags(32'h0);
		smp(16'h7021, 1'b0);
		flags(32'h40);
		close_out;
	end
endmodule // adc_result_postprocess_limits_tb

// ==== temp_gain_mult.v ====
`timescale 1ns/1ps
// Fixed-point gain, fourteen fraction bits, one register stage
module temp_gain_mult #(
	parameter DATA_W = 16,
	parameter GAIN_W = 15,
	parameter FRAC_W = 14
) (
	// Clock and reset
	input wire clock,
	input wire srst,
	// Sample in
	input wire in_valid,
	input wire [DATA_W-1:0] in_data,
	input wire apply_gain,
	input wire [GAIN_W-1:0] gain,
	// Sample out
	output reg out_valid_ff,
	output reg [DATA_W-1:0] out_data_ff
);
	wire [DATA_W+GAIN_W-1:0] product;
	wire [DATA_W+GAIN_W-1:0] shifted;
	wire [DATA_W+GAIN_W-1:0] max_code;
	reg [DATA_W-1:0] nxt_out_data;

	// Bit 14 weighs one, so 0x4000 is unity and every code is a factor below two
	assign product = in_data * gain;
	assign shifted = product >> FRAC_W;
	assign max_code = {{GAIN_W{1'b0}}, {DATA_W{1'b1}}};

	// Saturate to the result range
	always @* begin
		nxt_out_data = in_data;
		if (apply_gain) begin
			if (gain == {GAIN_W{1'b0}})
				nxt_out_data = {DATA_W{1'b0}};
			else if (shifted > max_code)
				nxt_out_data = {DATA_W{1'b1}};
			else
				nxt_out_data = shifted[DATA_W-1:0];
		end
	end

	// Output register
	always @(posedge clock) begin
		if (srst) begin
			out_valid_ff <= 1'b0;
			out_data_ff <= {DATA_W{1'b0}};
		end else begin
			out_valid_ff <= in_valid;
			out_data_ff <= nxt_out_data;
		end
	end
endmodule // temp_gain_mult
